// File: dv/serial_far_end.sv
// remote serial device: drives the receive line, listens on the transmit line
// assumes one bit lasts BitClk clocks of the block clock
`timescale 1ns/1ns
module serial_far_end #(
   parameter int BitClk = 16
)(
   // clock
   input wire logic clock,
   // line
   input wire logic txPin,
   input wire logic txPinOe,
   output logic rxPin
);
   logic [7:0] got[$];
   logic [7:0] sh;
   logic line;
   // released pin is pulled up
   assign line = txPinOe ? txPin : 1'b1;
   initial rxPin = 1'b1;
   task automatic sendByte(input logic [7:0] d, input logic badStop);
      logic [9:0] fr;
      fr = {~badStop, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         rxPin <= fr[i];
         repeat (BitClk) @(posedge clock);
      end
      rxPin <= 1'b1;
      // one edge passes before a following frame drives the line again
      @(posedge clock);
   endtask
   always
   begin
      @(negedge line);
      repeat (BitClk / 2) @(posedge clock);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BitClk) @(posedge clock);
         sh[i] = line;
      end
      got.push_back(sh);
      repeat (BitClk) @(posedge clock);
   end
endmodule // serial_far_end

// File: dv/serial_port_status_flags_bench.sv
// self-checking bench of the serial flag block with a remote serial partner
// assumes package, monitor and far-end model compiled first
`timescale 1ns/1ns
module serial_port_status_flags_bench;
   import uart_flags_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   apb_req_s req = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rxPin;
   logic txPin;
   logic txPinOe;
   logic irq;
   logic [31:0] q;
   logic err;
   logic [7:0] b0;
   logic [7:0] b1;
   int num_errors = 0;
   int n_compared = 0;
   int seed = 32'h02cd;
   always #5 clock = ~clock;
   serial_port_status_flags uut (.clock(clock), .nrst(nrst), .apbReq(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxPin(rxPin), .txPin(txPin), .txPinOe(txPinOe),
      .irq(irq));
   serial_far_end far (.clock(clock), .txPin(txPin), .txPinOe(txPinOe), .rxPin(rxPin));
   task automatic test_done();
      if (num_errors == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] fl(input int b);
      return 32'h1 << b;
   endfunction
   task automatic clk(input int n);
      repeat (n) @(posedge clock);
   endtask
   // one apb transfer; q and err taken at the completing edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clock);
      req.penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   // write a byte and wait until its start bit is on the line
   task automatic txStart(input logic [7:0] b);
      apb(1'b1, DATA_ADDR, {24'h0, b});
      for (int i = 0; i < 400 && txPin; i++) @(posedge clock);
   endtask
   initial
   begin
      clk(20000);
      num_errors++;
      test_done();
   end
   initial
   begin
      clk(4);
      nrst <= 1'b1;
      rd(CTRL_ADDR, 32'hffffffff, {30'h0, CTRL_RESET});
      rd(STATUS_ADDR, 32'hffffffff, 32'h0);
      rd(8'h14, 32'hffffffff, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, BAUD_ADDR, 32'h0);
      apb(1'b1, MASK_ADDR, 32'h7f);
      rd(MASK_ADDR, 32'hffffffff, {25'h0, MASK_WRITABLE});
      for (int m = 0; m < 2; m++)
      begin
         apb(1'b1, STATUS_ADDR, 32'h7f);
         apb(1'b1, MASK_ADDR, fl(m));
         apb(1'b1, CTRL_ADDR, 32'h3);
         rd(STATUS_ADDR, 32'h3, 32'h3);
         chk({31'h0, irq}, 32'h1);
         apb(1'b1, MASK_ADDR, 32'h0);
         clk(2);
         chk({31'h0, irq}, 32'h0);
         apb(1'b1, CTRL_ADDR, 32'h2);
         clk(40);
         chk({31'h0, txPinOe}, 32'h0);
      end
      // ----
      // transmit two, then disable with one queued
      // ----
      apb(1'b1, CTRL_ADDR, 32'h3);
      b0 = 8'($random(seed));
      b1 = 8'($random(seed));
      txStart(b0);
      apb(1'b1, DATA_ADDR, {24'h0, b1});
      apb(1'b1, STATUS_ADDR, fl(ST_TX_EMPTY));
      for (int i = 0; i < 800 && far.got.size() < 2; i++) @(posedge clock);
      chk({far.got[0], far.got[1]}, {16'h0, b0, b1});
      clk(40);
      rd(STATUS_ADDR, 32'h3, 32'h3);
      txStart(b1);
      apb(1'b1, DATA_ADDR, {24'h0, b0});
      apb(1'b1, STATUS_ADDR, 32'h3);
      apb(1'b1, CTRL_ADDR, 32'h2);
      for (int i = 0; i < 400 && txPinOe; i++) @(posedge clock);
      clk(200);
      chk(32'(far.got.size()), 32'h3);
      chk({24'h0, far.got[2]}, {24'h0, b1});
      rd(STATUS_ADDR, 32'h3, 32'h3);
      // receiver off: a character on the line is ignored
      apb(1'b1, CTRL_ADDR, 32'h0);
      far.sendByte(b1, 1'b0);
      clk(20);
      rd(STATUS_ADDR, 32'h3c, 32'h0);
      apb(1'b1, CTRL_ADDR, 32'h2);
      // ----
      // receive: full, clear, idle, overrun, framing
      // ----
      apb(1'b1, STATUS_ADDR, 32'h7f);
      apb(1'b1, MASK_ADDR, fl(ST_RX_FULL));
      far.sendByte(b0, 1'b0);
      clk(20);
      rd(STATUS_ADDR, 32'h3c, fl(ST_RX_FULL));
      chk({31'h0, irq}, 32'h1);
      rd(DATA_ADDR, 32'hff, {24'h0, b0});
      rd(STATUS_ADDR, 32'h7c, 32'h0);
      clk(200);
      rd(STATUS_ADDR, fl(ST_IDLE), fl(ST_IDLE));
      apb(1'b1, STATUS_ADDR, fl(ST_IDLE));
      clk(400);
      rd(STATUS_ADDR, fl(ST_IDLE), 32'h0);
      far.sendByte(b1, 1'b0);
      far.sendByte(b0, 1'b0);
      clk(20);
      rd(STATUS_ADDR, 32'hc, 32'hc);
      chk({31'h0, irq}, 32'h1);
      rd(DATA_ADDR, 32'hff, {24'h0, b1});
      apb(1'b1, STATUS_ADDR, 32'h7f);
      far.sendByte(b1, 1'b1);
      clk(20);
      rd(STATUS_ADDR, fl(ST_FRAMING), fl(ST_FRAMING));
      apb(1'b1, MASK_ADDR, 32'h38);
      clk(2);
      chk({31'h0, irq}, 32'h0);
      // reset in mid-character drops the pin at once
      apb(1'b1, CTRL_ADDR, 32'h3);
      txStart(b0);
      nrst <= 1'b0;
      @(negedge clock);
      chk({30'h0, txPinOe, txPin}, 32'h1);
      test_done();
   end
endmodule // serial_port_status_flags_bench
bind serial_port_status_flags uart_flags_monitor mon (.clock(clock), .nrst(nrst),
   .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxPin(rxPin),
   .txPin(txPin), .txPinOe(txPinOe), .irq(irq));

// File: dv/uart_flags_monitor.sv
// assertions on the ports of the serial flag block
// bound from the bench top file; sees block ports only
`timescale 1ns/1ns
module uart_flags_monitor
   import uart_flags_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // register bus
   input wire uart_flags_pkg::apb_req_s apbReq,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // pins
   input wire logic rxPin,
   input wire logic txPin,
   input wire logic txPinOe,
   input wire logic irq
);
   logic [1:0] ctrlCopy_ff;
   logic [6:0] maskCopy_ff;
   logic acc;
   assign acc = apbReq.psel && apbReq.penable;
   // ----
   // shadows, updated at the same edge as the block
   // ----
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrlCopy_ff <= 2'h0;
         maskCopy_ff <= 7'h00;
      end
      else if (acc && apbReq.pwrite)
      begin
         if (apbReq.paddr == CTRL_ADDR)
            ctrlCopy_ff <= apbReq.pwdata[1:0];
         if (apbReq.paddr == MASK_ADDR)
            maskCopy_ff <= apbReq.pwdata[6:0];
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence s_txOn;
      acc && apbReq.pwrite && apbReq.paddr == CTRL_ADDR && apbReq.pwdata[0] && !ctrlCopy_ff[0];
   endsequence
   sequence s_maskRead;
      acc && !apbReq.pwrite && apbReq.paddr == MASK_ADDR;
   endsequence
   a_off_line_high: assert property (!txPinOe |-> txPin)
      else $error("released pin not high");
   a_release_at_stop: assert property ($fell(txPinOe) |-> $past(txPin) && $past(txPin, 2))
      else $error("pin released inside a character");
   a_enable_owns_pin: assert property (s_txOn |-> ##[1:2] txPinOe)
      else $error("enable did not take the pin");
   a_empty_irq_on: assert property (s_txOn ##0 maskCopy_ff[0] |-> ##[1:3] irq)
      else $error("enable gave no empty interrupt");
   a_done_irq_on: assert property (s_txOn ##0 maskCopy_ff[1] |-> ##[1:3] irq)
      else $error("enable gave no done interrupt");
   a_irq_needs_mask: assert property ((maskCopy_ff == 7'h00) [*2] |-> !irq)
      else $error("interrupt with all enables off");
   a_mask_read_back: assert property (s_maskRead |-> prdata == {25'h0, maskCopy_ff & MASK_WRITABLE})
      else $error("mask read back wrong");
   a_status_width: assert property (acc && !apbReq.pwrite && apbReq.paddr == STATUS_ADDR |-> prdata[31:7] == 25'h0)
      else $error("status upper bits set");
endmodule // uart_flags_monitor

// File: rtl/serial_port_status_flags.sv
// status flags, interrupt request and shift logic of an async serial port
// assumes apb on the same clock; rx pin is asynchronous to it
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ns
module serial_port_status_flags #(
   parameter int DivWidth = 16
)(
   // clock and reset
   input wire logic clock,
   input wire logic nrst,
   // apb slave
   input wire uart_flags_pkg::apb_req_s apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial pins
   input wire logic rxPin,
   output logic txPin,
   output logic txPinOe,
   // interrupt
   output logic irq
);
   import uart_flags_pkg::*;

   generate
      if (DivWidth < 1 || DivWidth > 16)
      begin : g_bad_width
         $error("DivWidth must lie in 1..16");
      end
      if ((BAUD_RESET >> DivWidth) != 16'h0)
      begin : g_bad_reset
         $error("DivWidth too narrow for the reset divisor");
      end
      // rx and tx rt counters wrap at 16, idle count is 8 bits
      if (RT_PER_BIT != 16 || FRAME_BITS > 16 || IDLE_RT > 256)
      begin : g_bad_timing
         $error("timing constants do not fit the counters");
      end
   endgenerate

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic [2:0] rxSync;
      logic [1:0] ctrl;
      logic [6:0] mask;
      logic [DivWidth-1:0] baud;
      logic [DivWidth-1:0] rtCnt;
      logic [6:0] status;
      logic [6:0] armed;
      tx_state_e txState;
      logic [3:0] txRt;
      logic [3:0] txBits;
      logic [9:0] txShift;
      logic [7:0] txBuf;
      logic txBufFull;
      logic [7:0] rxBuf;
      logic rxActive;
      logic [3:0] rxRt;
      logic [3:0] rxBits;
      logic [7:0] rxShift;
      logic [2:0] rxSamp;
      logic rxNoise;
      logic rxLine;
      logic [7:0] idleCnt;
      logic lineBusy;
      logic [31:0] rdata;
   } state_s;

   state_s state_ff;
   state_s nxt_state;

   logic setupPh;
   logic accessPh;
   logic mapped;
   logic rtTick;
   logic txTick;
   logic [6:0] setBits;
   logic [6:0] clrBits;
   logic [6:0] maskEff;
   logic maj;
   logic [3:0] rtNext;

   assign setupPh = apbReq.psel && !apbReq.penable;
   assign accessPh = apbReq.psel && apbReq.penable;
   assign mapped = apbReq.paddr inside {CTRL_ADDR, STATUS_ADDR, DATA_ADDR,
      MASK_ADDR, BAUD_ADDR};
   assign pready = 1'b1;
   assign pslverr = accessPh && !mapped;
   assign rtTick = state_ff.rtCnt == '0;
   assign txTick = rtTick && state_ff.txRt == RT_LAST;
   assign maj = (state_ff.rxSamp[0] & state_ff.rxSamp[1])
      | (state_ff.rxSamp[0] & state_ff.rxSamp[2])
      | (state_ff.rxSamp[1] & state_ff.rxSamp[2]);
   assign rtNext = state_ff.rxRt + 4'h1;

   // full and overrun share one enable; noise and framing never interrupt
   always_comb
   begin
      maskEff = state_ff.mask & MASK_WRITABLE;
      maskEff[ST_OVERRUN] = state_ff.mask[ST_RX_FULL];
      maskEff[ST_NOISE] = 1'b0;
      maskEff[ST_FRAMING] = 1'b0;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      setBits = '0;
      clrBits = '0;

      // three stage synchroniser, change taken when stages 2 and 3 agree
      nxt_state.rxSync = {state_ff.rxSync[1:0], rxPin};
      if (state_ff.rxSync[1] == state_ff.rxSync[2])
      begin
         nxt_state.rxLine = state_ff.rxSync[2];
      end

      // 16x bit-rate enable from the divider
      if (rtTick)
      begin
         nxt_state.rtCnt = state_ff.baud;
         nxt_state.txRt = state_ff.txRt + 4'h1;
      end
      else
      begin
         nxt_state.rtCnt = state_ff.rtCnt - 1'b1;
      end

      // ------------------------------------------------------------
      // register bus
      // ------------------------------------------------------------
      // apb: read data captured in setup so it comes from a flop
      if (setupPh && !apbReq.pwrite)
      begin
         unique case (apbReq.paddr)
            CTRL_ADDR: nxt_state.rdata = 32'(state_ff.ctrl);
            STATUS_ADDR: nxt_state.rdata = 32'(state_ff.status);
            DATA_ADDR: nxt_state.rdata = 32'(state_ff.rxBuf);
            MASK_ADDR: nxt_state.rdata = 32'(state_ff.mask);
            BAUD_ADDR: nxt_state.rdata = 32'(state_ff.baud);
            default: nxt_state.rdata = 32'h0;
         endcase
      end

      if (accessPh)
      begin
         if (apbReq.pwrite)
         begin
            unique case (apbReq.paddr)
               CTRL_ADDR:
               begin
                  nxt_state.ctrl = apbReq.pwdata[1:0];
                  if (apbReq.pwdata[CTRL_TX_ON] && !state_ff.ctrl[CTRL_TX_ON])
                  begin
                     setBits[ST_TX_EMPTY] = 1'b1;
                     setBits[ST_TX_DONE] = 1'b1;
                  end
               end
               STATUS_ADDR: clrBits = clrBits | apbReq.pwdata[6:0];
               DATA_ADDR:
               begin
                  // writes while disabled are dropped, nothing will send them
                  // a second write before the load replaces the queued byte
                  if (state_ff.ctrl[CTRL_TX_ON])
                  begin
                     nxt_state.txBuf = apbReq.pwdata[7:0];
                     nxt_state.txBufFull = 1'b1;
                  end
               end
               MASK_ADDR: nxt_state.mask = apbReq.pwdata[6:0] & MASK_WRITABLE;
               BAUD_ADDR: nxt_state.baud = apbReq.pwdata[DivWidth-1:0];
               default: ;
            endcase
         end
         if (apbReq.paddr == STATUS_ADDR && !apbReq.pwrite)
         begin
            // arm only what the read returned; a flag set since stays up
            nxt_state.armed = state_ff.rdata[6:0];
         end
         if (apbReq.paddr == DATA_ADDR)
         begin
            clrBits = clrBits | state_ff.armed;
            nxt_state.armed = '0;
         end
      end

      // ------------------------------------------------------------
      // transmitter
      // ------------------------------------------------------------
      unique case (state_ff.txState)
         TX_OFF:
         begin
            nxt_state.txBufFull = 1'b0;
            if (state_ff.ctrl[CTRL_TX_ON])
            begin
               nxt_state.txState = TX_IDLE;
            end
         end
         TX_IDLE:
         begin
            if (txTick)
            begin
               if (!state_ff.ctrl[CTRL_TX_ON])
               begin
                  nxt_state.txState = TX_OFF;
                  nxt_state.txBufFull = 1'b0;
               end
               else if (state_ff.txBufFull)
               begin
                  nxt_state.txShift = {1'b1, state_ff.txBuf, 1'b0};
                  nxt_state.txBufFull = 1'b0;
                  nxt_state.txBits = '0;
                  nxt_state.txState = TX_SHIFT;
                  setBits[ST_TX_EMPTY] = 1'b1;
               end
            end
         end
         TX_SHIFT:
         begin
            // a cleared enable waits here for the frame end
            if (txTick)
            begin
               nxt_state.txShift = {1'b1, state_ff.txShift[9:1]};
               nxt_state.txBits = state_ff.txBits + 4'h1;
               if (state_ff.txBits == BIT_LAST)
               begin
                  if (!state_ff.ctrl[CTRL_TX_ON])
                  begin
                     nxt_state.txState = TX_LEAVE;
                     nxt_state.txBufFull = 1'b0;
                     setBits[ST_TX_EMPTY] = 1'b1;
                     setBits[ST_TX_DONE] = 1'b1;
                  end
                  else if (state_ff.txBufFull)
                  begin
                     nxt_state.txShift = {1'b1, state_ff.txBuf, 1'b0};
                     nxt_state.txBufFull = 1'b0;
                     nxt_state.txBits = '0;
                     setBits[ST_TX_EMPTY] = 1'b1;
                  end
                  else
                  begin
                     nxt_state.txState = TX_IDLE;
                     setBits[ST_TX_DONE] = 1'b1;
                  end
               end
            end
         end
         TX_LEAVE:
         begin
            nxt_state.txState = TX_OFF;
         end
      endcase

      // ------------------------------------------------------------
      // receiver
      // ------------------------------------------------------------
      if (rtTick && state_ff.ctrl[CTRL_RX_ON])
      begin
         if (!state_ff.rxActive)
         begin
            if (!state_ff.rxLine)
            begin
               nxt_state.rxActive = 1'b1;
               nxt_state.rxRt = '0;
               nxt_state.rxBits = '0;
               nxt_state.rxNoise = 1'b0;
               nxt_state.lineBusy = 1'b1;
            end
         end
         else
         begin
            nxt_state.rxRt = rtNext;
            if (state_ff.rxRt inside {4'h7, 4'h8, 4'h9})
            begin
               nxt_state.rxSamp = {state_ff.rxSamp[1:0], state_ff.rxLine};
            end
            if (state_ff.rxRt == RT_LAST)
            begin
               if (!(&state_ff.rxSamp) && (|state_ff.rxSamp))
               begin
                  nxt_state.rxNoise = 1'b1;
               end
               nxt_state.rxBits = state_ff.rxBits + 4'h1;
               if (state_ff.rxBits == 4'h0 && maj)
               begin
                  // glitch, not a start bit
                  nxt_state.rxActive = 1'b0;
               end
               else if (state_ff.rxBits == BIT_LAST)
               begin
                  nxt_state.rxActive = 1'b0;
                  if (state_ff.status[ST_RX_FULL])
                  begin
                     setBits[ST_OVERRUN] = 1'b1;
                  end
                  else
                  begin
                     nxt_state.rxBuf = state_ff.rxShift;
                     setBits[ST_RX_FULL] = 1'b1;
                     setBits[ST_NOISE] = nxt_state.rxNoise;
                     setBits[ST_FRAMING] = !maj;
                     clrBits[ST_NOISE] = !nxt_state.rxNoise;
                     clrBits[ST_FRAMING] = maj;
                  end
               end
               else if (state_ff.rxBits != 4'h0)
               begin
                  nxt_state.rxShift = {maj, state_ff.rxShift[7:1]};
               end
            end
         end
      end
      else if (!state_ff.ctrl[CTRL_RX_ON])
      begin
         // a disabled receiver drops any half-received character
         nxt_state.rxActive = 1'b0;
      end

      // ------------------------------------------------------------
      // idle detection
      // ------------------------------------------------------------
      // idle line: one full character time of ones
      if (!state_ff.rxLine || state_ff.rxActive)
      begin
         nxt_state.idleCnt = '0;
      end
      else if (rtTick && state_ff.idleCnt != IDLE_LAST)
      begin
         nxt_state.idleCnt = state_ff.idleCnt + 8'h1;
      end
      else if (state_ff.idleCnt == IDLE_LAST && state_ff.lineBusy)
      begin
         setBits[ST_IDLE] = 1'b1;
         nxt_state.lineBusy = 1'b0;
      end

      // ------------------------------------------------------------
      // flag update
      // ------------------------------------------------------------
      // set wins over a clear in the same cycle
      nxt_state.status = (state_ff.status & ~clrBits) | setBits;
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         // reset abandons any frame in progress
         state_ff <= '{rxSync: 3'h7, ctrl: CTRL_RESET, mask: MASK_RESET,
            baud: DivWidth'(BAUD_RESET), txState: TX_OFF, txShift: 10'h3ff,
            rxLine: 1'b1, default: '0};
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign prdata = state_ff.rdata;
   assign txPin = state_ff.txState == TX_SHIFT ? state_ff.txShift[0] : 1'b1;
   assign txPinOe = state_ff.txState != TX_OFF;
   assign irq = |(state_ff.status & maskEff);

endmodule // serial_port_status_flags

// File: rtl/uart_flags_pkg.sv
// constants, field layout and bus carrier of the serial port flag block
// assumes an apb master on the same clock as the block
//
// Summary of operation
// - flags other than noise and framing stay set until software clears them
// - enabling transmitter sets empty and done flags
// - empty flag set when buffer can take more
// - empty flag interrupts only when its enable set
// - done flag marks queue sent, own enable
// - disable only requests stop, character finishes
// - only reset stops transmitter at once
// - idle disable releases pin on bit tick
// - busy disable finishes character, drops queued one
// - last character still sets empty and done
// - five receive flags, three can interrupt
// - full flag set when character reaches buffer
// - overrun drops new character, buffer unchanged
// - overrun sets overrun flag instead of full
// - noise and framing describe buffer, no interrupt
// - line idle after one character time high
// - idle flag only on busy-to-idle change
package uart_flags_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] DATA_ADDR = 8'h08;
   localparam logic [7:0] MASK_ADDR = 8'h0c;
   localparam logic [7:0] BAUD_ADDR = 8'h10;

   // ------------------------------------------------------------
   // fields
   // ------------------------------------------------------------
   localparam int CTRL_TX_ON = 0;
   localparam int CTRL_RX_ON = 1;
   localparam int ST_TX_EMPTY = 0;
   localparam int ST_TX_DONE = 1;
   localparam int ST_RX_FULL = 2;
   localparam int ST_OVERRUN = 3;
   localparam int ST_NOISE = 4;
   localparam int ST_FRAMING = 5;
   localparam int ST_IDLE = 6;
   localparam logic [6:0] MASK_WRITABLE = 7'h47;

   // ------------------------------------------------------------
   // reset values and timing counts
   // ------------------------------------------------------------
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [6:0] MASK_RESET = 7'h00;
   localparam logic [15:0] BAUD_RESET = 16'h0035;
   localparam int RT_PER_BIT = 16;
   localparam int FRAME_BITS = 10;
   localparam int IDLE_RT = RT_PER_BIT * FRAME_BITS;
   localparam logic [3:0] RT_LAST = 4'(RT_PER_BIT - 1);
   localparam logic [3:0] BIT_LAST = 4'(FRAME_BITS - 1);
   localparam logic [7:0] IDLE_LAST = 8'(IDLE_RT - 1);

   typedef struct packed
   {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef enum logic [1:0]
   {
      TX_OFF = 2'b00,
      TX_IDLE = 2'b01,
      TX_SHIFT = 2'b11,
      TX_LEAVE = 2'b10
   } tx_state_e;

endpackage
